// ===== tb.sv
/*
 * self-checking bench for the context status register bank: register
 * port tasks, event scenarios through the pipeline model, verdict.
 * assumes: context 0, 20 MHz clock, inputs driven just after rising edges.
 */
`timescale 1ns/1ps
`default_nettype none

// compare and count one value
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("FAIL %0t got %h expected %h", $time, got, exp); end end

module tb;
    import tsr_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0;     // register address
    logic [31:0] wdata = 32'h0;   // write data
    wire logic [31:0] rdata, restart_q, pc;
    wire logic        h, hd, re, rx, rr, dm, sp, rl, sacc, racc, ds, dt, da, lv, ix;
    wire logic [1:0]  spm, pm;
    wire logic [7:0]  sid, id;
    int          n_fail = 0, cmp_count = 0, cyc = 0;
    logic [31:0] v;               // last read word

    tsr_pipe_model i_pipe (.clk(clk), .halt_evt(h), .halt_in_dslot(hd), .halt_restart_pc(pc),
        .retire_evt(re), .retire_exl(rx), .retire_erl(rr), .debug_mode(dm), .spawn_evt(sp),
        .spawn_priv_mode(spm), .spawn_addr_space_id(sid), .release_evt(rl));
    tsr_top #(.CTX_ID(8'h00)) i_dut (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .halt_evt(h), .halt_in_dslot(hd), .halt_restart_pc(pc),
        .retire_evt(re), .retire_exl(rx), .retire_erl(rr), .debug_mode(dm), .spawn_evt(sp),
        .spawn_priv_mode(spm), .spawn_addr_space_id(sid), .release_evt(rl), .spawn_accept(sacc),
        .release_accept(racc), .delay_slot_halt(ds), .dirty_flag(dt), .dynamic_alloc_enable(da),
        .tc_live(lv), .thread_priv_mode(pm), .irq_exempt(ix), .thread_addr_space_id(id),
        .thread_restart_addr(restart_q));

    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    // one-cycle write; data line shows the inverse once released
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk); wr <= 1'b0; wdata <= ~d;
        #1;
    endtask
    // one-cycle read; data taken in the following cycle only
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk); rd <= 1'b1; addr <= a;
        @(posedge clk); rd <= 1'b0;
        #1 v = rdata;
    endtask
    // synchronous reset held three cycles
    task automatic do_reset();
        @(posedge clk); srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
    endtask
    // reset state of the context word and the live flag
    task automatic t_reset();
        rd_reg(TSR_OFS_TCS);     `CHK(v, 32'h0000_2000)
        `CHK(lv, 1'b1)
    endtask
    // all-ones write: reserved, impl and delay bits stay zero; views agree
    task automatic t_fields();
        wr_reg(TSR_OFS_TCS, 32'hFFFF_FFFF);
        rd_reg(TSR_OFS_TCS);     `CHK(v, 32'hF810_BCFF)
        rd_reg(TSR_OFS_STATUS);  `CHK(v, 32'hF100_0018)
        rd_reg(TSR_OFS_TLB_ENTRY_HIGH); `CHK(v, 32'h0000_00FF)
        wr_reg(4'h2, 32'hFFFF_FFFF);
        rd_reg(4'h2);            `CHK(v, 32'h0000_0000)
    endtask
    // writes through the status and entry-high views show in the context word
    task automatic t_alias();
        wr_reg(TSR_OFS_STATUS, 32'h2000_0008);
        rd_reg(TSR_OFS_TCS);     `CHK(v, 32'h2010_ACFF)
        `CHK(pm, 2'h1)
        wr_reg(TSR_OFS_TLB_ENTRY_HIGH, 32'h0000_005A);
        rd_reg(TSR_OFS_TCS);     `CHK(v, 32'h2010_AC5A)
        `CHK(id, 8'h5A)
    endtask
    // retirement marks the context dirty unless exl, erl, debug or frozen
    task automatic t_dirty();
        wr_reg(TSR_OFS_TCS, 32'h0);  `CHK(dt, 1'b0)
        i_pipe.retire(1'b1, 1'b0, 1'b0); #1 `CHK(dt, 1'b0)
        i_pipe.retire(1'b0, 1'b1, 1'b0); #1 `CHK(dt, 1'b0)
        i_pipe.retire(1'b0, 1'b0, 1'b1); #1 `CHK(dt, 1'b0)
        ce <= 1'b0;
        i_pipe.retire(1'b0, 1'b0, 1'b0); ce <= 1'b1; #1 `CHK(dt, 1'b0)
        i_pipe.retire(1'b0, 1'b0, 1'b0); #1 `CHK(dt, 1'b1)
    endtask
    // spawn and release honoured only with allocation enabled
    task automatic t_spawn();
        wr_reg(TSR_OFS_TCS, 32'h0);
        i_pipe.spawn(2'h2, 8'h33); #1 `CHK({sacc, lv, dt}, 3'b000)
        wr_reg(TSR_OFS_TCS, 32'h0000_8400);
        i_pipe.spawn(2'h2, 8'h33); #1 `CHK({sacc, lv, dt, ds}, 4'b1110)
        `CHK({pm, id, ix}, {2'h2, 8'h33, 1'b1})
        @(posedge clk); #1 `CHK(sacc, 1'b0)
        i_pipe.release_ctx(); #1 `CHK({racc, lv}, 2'b10)
        wr_reg(TSR_OFS_TCS, 32'h0000_2000);
        i_pipe.release_ctx(); #1 `CHK({racc, lv}, 2'b01)
    endtask
    // delay-slot halt flag set, held against writes, cleared by restart write
    task automatic t_halt();
        i_pipe.halt(1'b1, 32'h0000_0100); #1 `CHK({ds, restart_q}, {1'b1, 32'h0000_0100})
        rd_reg(TSR_OFS_TCS);     `CHK(v[TSR_DS_BIT], 1'b1)
        wr_reg(TSR_OFS_TCS, 32'h0);  `CHK(ds, 1'b1)
        wr_reg(TSR_OFS_RESTART, 32'h0000_0200); `CHK(ds, 1'b0)
        rd_reg(TSR_OFS_RESTART); `CHK(v, 32'h0000_0200)
        i_pipe.halt(1'b1, 32'h0000_0300);
        i_pipe.halt(1'b0, 32'h0000_0304); #1 `CHK({ds, restart_q}, {1'b0, 32'h0000_0304})
        i_pipe.halt(1'b1, 32'h0000_0400);
        do_reset(); #1 `CHK(ds, 1'b0)
        t_reset();
    endtask
    // verdict and end of run
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // main sequence
    initial begin
        do_reset();
        t_reset();
        t_fields();
        t_alias();
        t_dirty();
        t_spawn();
        t_halt();
        report_and_stop();
    end
endmodule

`default_nettype wire

// ===== tsr_pipe_model.sv
/*
 * pipeline and scheduler stand-in: pulses halt, retire, spawn and release
 * events into one context, each qualifier held level with its pulse.
 * assumes: tasks are called from the bench, one event at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module tsr_pipe_model (
    input  wire logic        clk,             // processor clock
    output logic             halt_evt,        // halt pulse
    output logic             halt_in_dslot,   // halted before a slot
    output logic      [31:0] halt_restart_pc, // restart pc
    output logic             retire_evt,      // retire pulse
    output logic             retire_exl,      // issued with exception_level
    output logic             retire_erl,      // issued with error_level
    output logic             debug_mode,      // debug mode level
    output logic             spawn_evt,       // spawn pulse
    output logic      [1:0]  spawn_priv_mode, // spawner privilege
    output logic      [7:0]  spawn_addr_space_id,      // spawner id
    output logic             release_evt      // release pulse
);
    // quiet lines at time zero
    initial begin
        {halt_evt, halt_in_dslot, retire_evt, retire_exl, retire_erl} = '0;
        {debug_mode, spawn_evt, release_evt} = '0;
        halt_restart_pc = 32'h0000_0000;
        spawn_priv_mode = 2'h0;
        spawn_addr_space_id      = 8'h00;
    end
    // halt with its qualifiers; released lines show the inverse afterwards
    task automatic halt(input logic ds, input logic [31:0] pc);
        @(posedge clk);
        halt_evt <= 1'b1; halt_in_dslot <= ds; halt_restart_pc <= pc;
        @(posedge clk);
        halt_evt <= 1'b0; halt_in_dslot <= ~ds; halt_restart_pc <= ~pc;
    endtask
    // one retirement with its status and debug levels
    task automatic retire(input logic exception_level, input logic error_level, input logic dbg);
        @(posedge clk);
        retire_evt <= 1'b1; retire_exl <= exception_level; retire_erl <= error_level; debug_mode <= dbg;
        @(posedge clk);
        retire_evt <= 1'b0; retire_exl <= ~exception_level; retire_erl <= ~error_level; debug_mode <= 1'b0;
    endtask
    // spawn carrying the spawner's privilege and id
    task automatic spawn(input logic [1:0] pm, input logic [7:0] id);
        @(posedge clk);
        spawn_evt <= 1'b1; spawn_priv_mode <= pm; spawn_addr_space_id <= id;
        @(posedge clk);
        spawn_evt <= 1'b0; spawn_priv_mode <= ~pm; spawn_addr_space_id <= ~id;
    endtask
    // release of register zero
    task automatic release_ctx();
        @(posedge clk);
        release_evt <= 1'b1;
        @(posedge clk);
        release_evt <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== tsr_pkg.sv
/*
 * package for the per-thread-context status register bank: software
 * offsets, field positions, reset values and values loaded on a spawn.
 * assumes: one context per instance, 32-bit register port, 4-bit address.
 */
`default_nettype none

package tsr_pkg;

    // register offsets on the plain software port (byte addresses)
    localparam logic [3:0] TSR_OFS_TCS     = 4'h0;  // thread_context_status
    localparam logic [3:0] TSR_OFS_STATUS  = 4'h4;  // global status view
    localparam logic [3:0] TSR_OFS_TLB_ENTRY_HIGH = 4'h8;  // tlb_entry_high view
    localparam logic [3:0] TSR_OFS_RESTART = 4'hC;  // thread_restart_addr

    // thread_context_status field positions
    localparam int TSR_CU_HI    = 31;  // coprocessor_usable top bit
    localparam int TSR_CU_LO    = 28;  // coprocessor_usable low bit
    localparam int TSR_MX_BIT   = 27;  // media_ext_enable
    localparam int TSR_DS_BIT   = 21;  // delay_slot_halt
    localparam int TSR_DT_BIT   = 20;  // dirty_flag
    localparam int TSR_IMPL_HI  = 19;  // implementation bits, not built
    localparam int TSR_IMPL_LO  = 16;
    localparam int TSR_DA_BIT   = 15;  // dynamic_alloc_enable
    localparam int TSR_LIVE_BIT = 13;  // tc_live
    localparam int TSR_KSU_HI   = 12;  // thread_priv_mode
    localparam int TSR_KSU_LO   = 11;
    localparam int TSR_IRQ_EXEMPT_BIT = 10;  // irq_exempt
    localparam int TSR_ADDR_SPACE_ID_HI  = 7;   // thread_addr_space_id
    localparam int TSR_ADDR_SPACE_ID_LO  = 0;

    // global status view field positions
    localparam int TSR_ST_CU_HI  = 31;
    localparam int TSR_ST_CU_LO  = 28;
    localparam int TSR_ST_MX_BIT = 24;
    localparam int TSR_ST_KSU_HI = 4;
    localparam int TSR_ST_KSU_LO = 3;

    // reset values
    localparam logic        TSR_RST_DS        = 1'b0;
    localparam logic        TSR_RST_DT        = 1'b0;
    localparam logic        TSR_RST_DA        = 1'b0;
    localparam logic        TSR_RST_IRQ_EXEMPT      = 1'b0;
    localparam logic        TSR_RST_LIVE_CTX0 = 1'b1;
    localparam logic        TSR_RST_LIVE_REST = 1'b0;
    localparam logic        TSR_RST_MX        = 1'b0;
    localparam logic [3:0]  TSR_RST_CU        = 4'h0;
    localparam logic [1:0]  TSR_RST_KSU       = 2'h0;
    localparam logic [7:0]  TSR_RST_ADDR_SPACE_ID      = 8'h00;
    localparam logic [31:0] TSR_RST_RESTART   = 32'h0000_0000;

    // values forced by a successful spawn
    localparam logic TSR_SPAWN_DS   = 1'b0;
    localparam logic TSR_SPAWN_DT   = 1'b1;
    localparam logic TSR_SPAWN_LIVE = 1'b1;

    // a translation buffer exists, so the address-space id is writable
    localparam logic TSR_TLB_PRESENT = 1'b1;

endpackage

`default_nettype wire

// ===== tsr_top.sv
/*
 * per-thread-context status register bank with its aliased views of the
 * global status register, the tlb entry-high id field and the restart
 * address. hardware events come from the pipeline and scheduler.
 * assumes: all inputs are on clk already, one context per instance.
 */
// Chosen here: the strobed register port and the register offsets.
// What this block does
// - delay-slot halt sets flag, restart holds branch
// - other halt or restart write clears flag
// - delay flag read-only, resets zero, spawn zeroes
// - retire or spawn dispatch sets dirty flag
// - no dirty on exception, error, debug retire
// - dirty flag writable, resets zero, spawn sets
// - implementation bits ignore writes, read zero
// - spawn and release act only when enabled
// - spawn sets live, release zero clears it
// - live writable, resets one only context zero
// - thread privilege mode copied on spawn
// - interrupt-exempt flag software-only, resets zero
// - thread id mirrors entry-high id, spawn copies
// - unit, media, privilege fields shared with status
// - reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none

module tsr_top
    import tsr_pkg::*;
#(
    parameter logic [7:0] CTX_ID = 8'h00         // index of this context
) (
    input  wire logic        clk,                // 20 MHz processor clock
    input  wire logic        srst,               // synchronous reset
    input  wire logic        ce,                 // clock enable
    input  wire logic [3:0]  addr,               // register address
    input  wire logic [31:0] wdata,              // write data
    input  wire logic        wr,                 // write strobe
    input  wire logic        rd,                 // read strobe
    output logic      [31:0] rdata,              // read data, cycle after rd
    input  wire logic        halt_evt,           // context halts this cycle
    input  wire logic        halt_in_dslot,      // next to issue is a slot
    input  wire logic [31:0] halt_restart_pc,    // restart (or branch) pc
    input  wire logic        retire_evt,         // instruction retires
    input  wire logic        retire_exl,         // issued with exception_level
    input  wire logic        retire_erl,         // issued with error_level
    input  wire logic        debug_mode,         // processor in debug mode
    input  wire logic        spawn_evt,          // thread_spawn picks context
    input  wire logic [1:0]  spawn_priv_mode,    // spawner's privilege mode
    input  wire logic [7:0]  spawn_addr_space_id,         // spawner's address-space id
    input  wire logic        release_evt,        // thread_release of reg zero
    output logic             spawn_accept,       // spawn took effect
    output logic             release_accept,     // release took effect
    output logic             delay_slot_halt,    // halted before a delay slot
    output logic             dirty_flag,         // context has run
    output logic             dynamic_alloc_enable, // spawn/release allowed
    output logic             tc_live,            // context activated
    output logic      [1:0]  thread_priv_mode,   // per-context privilege
    output logic             irq_exempt,         // exempt from interrupts
    output logic      [7:0]  thread_addr_space_id, // per-context id
    output logic      [31:0] thread_restart_addr // restart address
);

    logic [3:0] cu_r;                            // coprocessor_usable
    logic       mx_r;                            // media_ext_enable
    logic       wr_tcs;                          // write to own register
    logic       wr_st;                           // write to status view
    logic       wr_eh;                           // write to entry-high view
    logic       wr_rs;                           // write to restart address
    logic       spawn_ok;                        // spawn permitted this cycle
    logic       rel_ok;                          // release permitted
    logic       retire_dirty;                    // retirement marks dirty
    logic [31:0] tcs_word;                       // composed register image
    logic [31:0] st_word;                        // composed status view
    logic [31:0] eh_word;                        // composed entry-high view
    logic [31:0] rdata_nxt;                      // read mux output

    // address decode and event qualification
    always_comb begin
        wr_tcs       = wr && (addr == TSR_OFS_TCS);
        wr_st        = wr && (addr == TSR_OFS_STATUS);
        wr_eh        = wr && (addr == TSR_OFS_TLB_ENTRY_HIGH);
        wr_rs        = wr && (addr == TSR_OFS_RESTART);
        spawn_ok     = spawn_evt && dynamic_alloc_enable;
        rel_ok       = release_evt && dynamic_alloc_enable && !spawn_evt;
        retire_dirty = retire_evt && !retire_exl && !retire_erl && !debug_mode;
    end

    // register images; reserved and implementation bits stay zero
    always_comb begin
        tcs_word                            = 32'h0000_0000;
        tcs_word[TSR_CU_HI:TSR_CU_LO]       = cu_r;
        tcs_word[TSR_MX_BIT]                = mx_r;
        tcs_word[TSR_DS_BIT]                = delay_slot_halt;
        tcs_word[TSR_DT_BIT]                = dirty_flag;
        tcs_word[TSR_DA_BIT]                = dynamic_alloc_enable;
        tcs_word[TSR_LIVE_BIT]              = tc_live;
        tcs_word[TSR_KSU_HI:TSR_KSU_LO]     = thread_priv_mode;
        tcs_word[TSR_IRQ_EXEMPT_BIT]              = irq_exempt;
        tcs_word[TSR_ADDR_SPACE_ID_HI:TSR_ADDR_SPACE_ID_LO]   = thread_addr_space_id;
        st_word                             = 32'h0000_0000;
        st_word[TSR_ST_CU_HI:TSR_ST_CU_LO]  = cu_r;
        st_word[TSR_ST_MX_BIT]              = mx_r;
        st_word[TSR_ST_KSU_HI:TSR_ST_KSU_LO] = thread_priv_mode;
        eh_word                             = 32'h0000_0000;
        eh_word[TSR_ADDR_SPACE_ID_HI:TSR_ADDR_SPACE_ID_LO]    = thread_addr_space_id;
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        unique case (addr)
            TSR_OFS_TCS:     rdata_nxt = tcs_word;
            TSR_OFS_STATUS:  rdata_nxt = st_word;
            TSR_OFS_TLB_ENTRY_HIGH: rdata_nxt = eh_word;
            TSR_OFS_RESTART: rdata_nxt = thread_restart_addr;
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data register, valid only in the cycle after rd
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    // delay-slot flag and restart address
    always_ff @(posedge clk) begin
        if (srst) begin
            delay_slot_halt     <= TSR_RST_DS;
            thread_restart_addr <= TSR_RST_RESTART;
        end else if (ce) begin
            if (halt_evt) begin
                // halt has priority over a software restart write
                delay_slot_halt     <= halt_in_dslot;
                thread_restart_addr <= halt_restart_pc;
            end else if (spawn_ok) begin
                delay_slot_halt     <= TSR_SPAWN_DS;
            end else if (wr_rs) begin
                delay_slot_halt     <= 1'b0;
                thread_restart_addr <= wdata;
            end
        end
    end

    // dirty flag: hardware set wins over a software clear
    always_ff @(posedge clk) begin
        if (srst) begin
            dirty_flag <= TSR_RST_DT;
        end else if (ce) begin
            if (spawn_ok) begin
                dirty_flag <= TSR_SPAWN_DT;
            end else if (retire_dirty) begin
                dirty_flag <= 1'b1;
            end else if (wr_tcs) begin
                dirty_flag <= wdata[TSR_DT_BIT];
            end
        end
    end

    // allocation enable and interrupt exemption, software only
    always_ff @(posedge clk) begin
        if (srst) begin
            dynamic_alloc_enable <= TSR_RST_DA;
            irq_exempt           <= TSR_RST_IRQ_EXEMPT;
        end else if (ce && wr_tcs) begin
            dynamic_alloc_enable <= wdata[TSR_DA_BIT];
            irq_exempt           <= wdata[TSR_IRQ_EXEMPT_BIT];
        end
    end

    // activated flag
    always_ff @(posedge clk) begin
        if (srst) begin
            tc_live <= (CTX_ID == 8'h00) ? TSR_RST_LIVE_CTX0 : TSR_RST_LIVE_REST;
        end else if (ce) begin
            if (spawn_ok) begin
                tc_live <= TSR_SPAWN_LIVE;
            end else if (rel_ok) begin
                tc_live <= 1'b0;
            end else if (wr_tcs) begin
                tc_live <= wdata[TSR_LIVE_BIT];
            end
        end
    end

    // fields shared with the global status view
    always_ff @(posedge clk) begin
        if (srst) begin
            cu_r             <= TSR_RST_CU;
            mx_r             <= TSR_RST_MX;
            thread_priv_mode <= TSR_RST_KSU;
        end else if (ce) begin
            if (spawn_ok) begin
                thread_priv_mode <= spawn_priv_mode;
            end else if (wr_tcs) begin
                thread_priv_mode <= wdata[TSR_KSU_HI:TSR_KSU_LO];
            end else if (wr_st) begin
                thread_priv_mode <= wdata[TSR_ST_KSU_HI:TSR_ST_KSU_LO];
            end
            if (wr_tcs) begin
                cu_r <= wdata[TSR_CU_HI:TSR_CU_LO];
                mx_r <= wdata[TSR_MX_BIT];
            end else if (wr_st) begin
                cu_r <= wdata[TSR_ST_CU_HI:TSR_ST_CU_LO];
                mx_r <= wdata[TSR_ST_MX_BIT];
            end
        end
    end

    // address-space id, one flop seen through both views
    always_ff @(posedge clk) begin
        if (srst) begin
            thread_addr_space_id <= TSR_RST_ADDR_SPACE_ID;
        end else if (ce && TSR_TLB_PRESENT) begin
            if (spawn_ok) begin
                thread_addr_space_id <= spawn_addr_space_id;
            end else if (wr_tcs || wr_eh) begin
                thread_addr_space_id <= wdata[TSR_ADDR_SPACE_ID_HI:TSR_ADDR_SPACE_ID_LO];
            end
        end
    end

    // accept pulses back to the scheduler
    always_ff @(posedge clk) begin
        if (srst) begin
            spawn_accept   <= 1'b0;
            release_accept <= 1'b0;
        end else if (ce) begin
            spawn_accept   <= spawn_ok;
            release_accept <= rel_ok;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_halt_ds;
        ce && halt_evt && halt_in_dslot;
    endsequence

    sequence s_plain_clear;
        ce && !halt_evt && !spawn_ok && wr_rs;
    endsequence

    sequence s_clean_retire;
        ce && retire_evt && (retire_exl || retire_erl || debug_mode) && !spawn_ok && !wr_tcs;
    endsequence

    AST_DS_SET: assert property (s_halt_ds |=> delay_slot_halt &&
        thread_restart_addr == $past(halt_restart_pc))
        else $error("delay-slot halt not recorded");
    AST_DS_CLR: assert property ((ce && halt_evt && !halt_in_dslot) or s_plain_clear
        |=> !delay_slot_halt)
        else $error("delay-slot flag not cleared");
    AST_DS_RO: assert property (ce && wr_tcs && !halt_evt && !spawn_ok
        |=> delay_slot_halt == $past(delay_slot_halt))
        else $error("delay-slot flag changed by software");
    AST_DT_SET: assert property (ce && retire_dirty |=> dirty_flag)
        else $error("retire did not mark dirty");
    AST_DT_INH: assert property (s_clean_retire |=> dirty_flag == $past(dirty_flag))
        else $error("inhibited retire changed dirty flag");
    AST_SPAWN: assert property (ce && spawn_evt && dynamic_alloc_enable
        |=> dirty_flag && tc_live && !delay_slot_halt && spawn_accept)
        else $error("spawn did not load context");
    AST_RD_ZERO: assert property (ce && rd && addr == TSR_OFS_TCS
        |=> rdata[TSR_IMPL_HI:TSR_IMPL_LO] == 4'h0 && rdata[25] == 1'b0 &&
            rdata[22] == 1'b0 && rdata[14] == 1'b0 && rdata[9:8] == 2'h0)
        else $error("reserved bits read nonzero");
    AST_DA_GATE: assert property (ce && !dynamic_alloc_enable
        |=> !spawn_accept && !release_accept)
        else $error("allocation while disabled");
    AST_REL: assert property (ce && rel_ok && !wr_tcs |=> !tc_live && release_accept)
        else $error("release did not clear live");
    AST_IRQ_EXEMPT_FORK: assert property (ce && spawn_ok && !wr_tcs
        |=> irq_exempt == $past(irq_exempt))
        else $error("spawn changed exemption");
    AST_ALIAS_KSU: assert property (ce && wr_st && !spawn_ok && !wr_tcs ##1 ce && rd
        && addr == TSR_OFS_TCS |=> rdata[TSR_KSU_HI:TSR_KSU_LO] ==
            $past(wdata[TSR_ST_KSU_HI:TSR_ST_KSU_LO], 2))
        else $error("status privilege write not seen in context view");
    AST_ALIAS_ADDR_SPACE_ID: assert property (ce && wr_tcs && !spawn_ok ##1 ce && rd
        && addr == TSR_OFS_TLB_ENTRY_HIGH |=> rdata[7:0] == $past(wdata[7:0], 2))
        else $error("id write not seen in entry-high view");

endmodule

`default_nettype wire
